// ---- rtl/pmu_clk_switch.sv ----
// Break-before-make selector for the system clock enables
`timescale 1ns/1ps
`include "pmu_defs.svh"
module pmu_clk_switch (
    input wire logic clk,
    input wire logic rst,
    input pmu_pkg::pmu_clk_sel_t sel,
    input wire logic fast_ok,
    input wire logic slow_ok,
    output logic main_en,
    output logic slow_en,
    output logic done
);
    import pmu_pkg::*;
    pmu_clk_sel_t cur_reg;
    pmu_clk_sel_t cur_next;
    logic [3:0] dead_reg;
    logic [3:0] dead_next;
    wire target_ok = (sel == PMU_SEL_NONE) || (sel == PMU_SEL_MAIN && fast_ok) ||
        (sel == PMU_SEL_SLOW && slow_ok);
    wire moving = cur_reg != sel;
    // Old clock off first, dead time, then new clock only once stable
    assign cur_next = !moving ? cur_reg :
        (cur_reg != PMU_SEL_NONE) ? PMU_SEL_NONE :
        (dead_reg == 4'h0 && target_ok) ? sel : cur_reg;
    assign dead_next = (moving && cur_reg != PMU_SEL_NONE) ? 4'(`PMU_DEAD_CYC) :
        (dead_reg != 4'h0) ? dead_reg - 4'h1 : dead_reg;
    // During reset the reset clock passes straight through if stable
    // Gate drops the cycle the mode leaves a clock, before the selector moves
    assign main_en = rst ? (sel == PMU_SEL_MAIN && fast_ok) :
        (cur_reg == PMU_SEL_MAIN && sel == PMU_SEL_MAIN && fast_ok);
    assign slow_en = rst ? (sel == PMU_SEL_SLOW && slow_ok) :
        (cur_reg == PMU_SEL_SLOW && sel == PMU_SEL_SLOW && slow_ok);
    assign done = !moving;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cur_reg <= PMU_SEL_NONE;
            dead_reg <= 4'h0;
        end
        else
        begin
            cur_reg <= cur_next;
            dead_reg <= dead_next;
        end
    end
    fast_use_a: assert property (@(posedge clk) main_en |-> fast_ok)
        else $error("main clock enabled while fast clock unstable");
    slow_use_a: assert property (@(posedge clk) slow_en |-> slow_ok)
        else $error("slow clock enabled while slow clock unstable");
    reset_clock_a: assert property (@(posedge clk) rst && sel == PMU_SEL_MAIN |->
        main_en == fast_ok && !slow_en)
        else $error("reset clock output not gated by its stable flag");
    dead_time_a: assert property (@(posedge clk) disable iff (rst)
        $changed(cur_reg) && cur_reg == PMU_SEL_NONE |-> (cur_reg == PMU_SEL_NONE)[*3])
        else $error("clock switched without dead time");
endmodule

// ---- rtl/pmu_defs.svh ----
// Bit positions, reset values and timing constants of the power mode unit
`ifndef PMU_DEFS_SVH
`define PMU_DEFS_SVH
`define PMU_SAVE_REQ_BIT 0
`define PMU_OSC_DIS_BIT 1
`define PMU_IDLE_BIT 2
`define PMU_HALT_BIT 3
`define PMU_DEFER_BIT 5
`define PMU_FAST_OK_BIT 6
`define PMU_SLOW_OK_BIT 7
`define PMU_CTL_RESET 8'h00
`define PMU_CLK_PERIOD_NS 10
`define PMU_DEAD_NS 20
`define PMU_DEAD_CYC ((`PMU_DEAD_NS + `PMU_CLK_PERIOD_NS - 1) / `PMU_CLK_PERIOD_NS)
`endif

// ---- rtl/pmu_pkg.sv ----
// Types shared by the power mode unit modules
package pmu_pkg;
    typedef enum logic [5:0] {
        PMU_ST_ACTIVE = 6'h01,
        PMU_ST_ENTER_SAVE = 6'h02,
        PMU_ST_SAVE = 6'h04,
        PMU_ST_IDLE = 6'h08,
        PMU_ST_HALT = 6'h10,
        PMU_ST_LEAVE = 6'h20
    } pmu_state_t;
    typedef enum logic [1:0] {
        PMU_SEL_NONE = 2'h0,
        PMU_SEL_MAIN = 2'h1,
        PMU_SEL_SLOW = 2'h2
    } pmu_clk_sel_t;
endpackage

// ---- rtl/pmu_top.sv ----
// Power mode unit: mode sequencing, oscillator and clock gating control
`timescale 1ns/1ps
`include "pmu_defs.svh"
module pmu_top (
    input wire logic MCLK,
    input wire logic SYS_RST,
    input wire logic FAST_CLOCK_STABLE,
    input wire logic SLOW_CLOCK_STABLE,
    input wire logic SLOW_SRC_LFO,
    input wire logic RESET_CLK_SLOW,
    input wire logic WAKE_IRQ,
    input wire logic NMI,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic WAIT_EXEC,
    input wire logic INT_REQ,
    input wire logic INT_ACK,
    output logic [7:0] REG_RDATA,
    output pmu_pkg::pmu_state_t MODE,
    output logic FAST_OSC_EN,
    output logic LOW_OSC_EN,
    output logic MAIN_CLK_EN,
    output logic SLOW_CLK_EN,
    output logic TIMER_CLK_EN,
    output logic PMU_CLK_EN,
    output logic CPU_STALL,
    output logic WAKE_PENDING
);
    import pmu_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Left unreset so the stable flags are seen while reset is held
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    always_ff @(posedge MCLK)
    begin
        sync1_reg <= {RESET_CLK_SLOW, NMI, WAKE_IRQ, SLOW_SRC_LFO,
            SLOW_CLOCK_STABLE, FAST_CLOCK_STABLE};
        sync2_reg <= sync1_reg;
    end
    wire fast_ok = sync2_reg[0];
    wire slow_ok = sync2_reg[1];
    wire lfo_src = sync2_reg[2];
    wire wake_irq_s = sync2_reg[3];
    wire nmi_s = sync2_reg[4];
    wire rst_clk_slow = sync2_reg[5];

    // ------------------------------------------------------------
    // Wake-up latch
    // ------------------------------------------------------------
    logic wake_pend;
    logic wake_evt;
    // Runs on the always-on control clock, so Halt cannot blind it
    pmu_wake_latch u_wake (
        .clk(MCLK),
        .rst(SYS_RST),
        .wake_irq(wake_irq_s),
        .nmi(nmi_s),
        .int_ack(INT_ACK),
        .pending(wake_pend),
        .wake_event(wake_evt)
    );

    // ------------------------------------------------------------
    // State and control bits
    // ------------------------------------------------------------
    pmu_state_t state_reg;
    pmu_state_t state_next;
    logic power_save_request_reg;
    logic power_save_request_next;
    logic fast_osc_disable_reg;
    logic fast_osc_disable_next;
    logic idle_reg;
    logic idle_next;
    logic halt_reg;
    logic halt_next;
    logic defer_save_until_wait_reg;
    logic defer_save_until_wait_next;
    logic stall_reg;
    logic stall_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    wire is_active = state_reg == PMU_ST_ACTIVE;
    wire is_enter = state_reg == PMU_ST_ENTER_SAVE;
    wire is_save = state_reg == PMU_ST_SAVE;
    wire is_idle = state_reg == PMU_ST_IDLE;
    wire is_halt = state_reg == PMU_ST_HALT;
    wire is_leave = state_reg == PMU_ST_LEAVE;
    wire asleep = is_enter || is_save || is_idle || is_halt;

    wire wr_save = REG_WDATA[`PMU_SAVE_REQ_BIT];
    wire wr_defer = REG_WDATA[`PMU_DEFER_BIT];
    logic sw_done;

    // ------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------
    // Immediate save: written with deferral clear, slow clock required
    wire save_now = REG_WR && is_active && wr_save && !wr_defer && slow_ok
        && !wake_evt;
    // Software exit from Power Save
    wire save_exit = REG_WR && is_save && !wr_save;
    // Deferred entries only through WAIT with the deferral bit set
    wire act_wait = WAIT_EXEC && is_active && defer_save_until_wait_reg && !wake_evt;
    wire act_halt = act_wait && halt_reg;
    wire act_idle = act_wait && !halt_reg && idle_reg && slow_ok;
    wire act_save = act_wait && !halt_reg && !idle_reg && power_save_request_reg
        && slow_ok;
    // Back to Active only while the main clock is really stable
    wire leave_done = is_leave && sw_done && fast_ok;
    wire go_halt = WAIT_EXEC && (is_save || is_idle) && halt_reg;
    wire go_idle = WAIT_EXEC && is_save && !halt_reg && idle_reg;

    // ------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            PMU_ST_ACTIVE:
            begin
                if (act_halt)
                    state_next = PMU_ST_HALT;
                else if (act_idle)
                    state_next = PMU_ST_IDLE;
                else if (act_save || save_now)
                    state_next = PMU_ST_ENTER_SAVE;
            end
            PMU_ST_ENTER_SAVE:
            begin
                if (wake_evt)
                    state_next = PMU_ST_LEAVE;
                else if (sw_done)
                    state_next = PMU_ST_SAVE;
            end
            PMU_ST_SAVE:
            begin
                if (wake_evt || save_exit)
                    state_next = PMU_ST_LEAVE;
                else if (go_halt)
                    state_next = PMU_ST_HALT;
                else if (go_idle)
                    state_next = PMU_ST_IDLE;
            end
            PMU_ST_IDLE:
            begin
                if (wake_evt)
                    state_next = PMU_ST_LEAVE;
                else if (go_halt)
                    state_next = PMU_ST_HALT;
            end
            PMU_ST_HALT:
            begin
                if (wake_evt)
                    state_next = PMU_ST_LEAVE;
            end
            PMU_ST_LEAVE:
            begin
                // Switch module holds main off until fast clock is stable
                if (leave_done)
                    state_next = PMU_ST_ACTIVE;
            end
            default:
                state_next = PMU_ST_ACTIVE;
        endcase
    end

    // ------------------------------------------------------------
    // Control/status bit updates
    // ------------------------------------------------------------
    // Wake-up clears beat any same-cycle software write
    assign fast_osc_disable_next = wake_evt ? 1'b0 :
        REG_WR ? REG_WDATA[`PMU_OSC_DIS_BIT] : fast_osc_disable_reg;
    assign idle_next = wake_evt ? 1'b0 :
        REG_WR ? REG_WDATA[`PMU_IDLE_BIT] : idle_reg;
    assign halt_next = wake_evt ? 1'b0 :
        REG_WR ? REG_WDATA[`PMU_HALT_BIT] : halt_reg;
    assign defer_save_until_wait_next = REG_WR ? wr_defer : defer_save_until_wait_reg;
    // Save bit: set on completion when immediate, at once when deferred
    assign power_save_request_next = leave_done ? 1'b0 :
        (is_enter && sw_done && !wake_evt) ? 1'b1 :
        (is_active && wake_evt) ? 1'b0 :
        (REG_WR && is_active) ? (wr_save && wr_defer) : power_save_request_reg;
    // WAIT stalls the core; only an interrupt releases it
    assign stall_next = WAIT_EXEC ? 1'b1 :
        (INT_REQ || (wake_pend && is_active)) ? 1'b0 : stall_reg;
    assign rdata_next = {slow_ok, fast_ok, defer_save_until_wait_reg, 1'b0,
        halt_reg, idle_reg, fast_osc_disable_reg, power_save_request_reg};

    always_ff @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            state_reg <= PMU_ST_ACTIVE;
            {power_save_request_reg, fast_osc_disable_reg, idle_reg, halt_reg} <= 4'h0;
            defer_save_until_wait_reg <= 1'b0;
            stall_reg <= 1'b0;
            rdata_reg <= `PMU_CTL_RESET;
        end
        else
        begin
            state_reg <= state_next;
            power_save_request_reg <= power_save_request_next;
            fast_osc_disable_reg <= fast_osc_disable_next;
            idle_reg <= idle_next;
            halt_reg <= halt_next;
            defer_save_until_wait_reg <= defer_save_until_wait_next;
            stall_reg <= stall_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Clock selection and gating
    // ------------------------------------------------------------
    wire pmu_clk_sel_t mode_sel = (is_active || is_leave) ? PMU_SEL_MAIN :
        (is_enter || is_save) ? PMU_SEL_SLOW : PMU_SEL_NONE;
    wire pmu_clk_sel_t rst_sel = rst_clk_slow ? PMU_SEL_SLOW : PMU_SEL_MAIN;
    wire pmu_clk_sel_t clk_sel = SYS_RST ? rst_sel : mode_sel;
    pmu_clk_switch u_switch (
        .clk(MCLK),
        .rst(SYS_RST),
        .sel(clk_sel),
        .fast_ok(fast_ok),
        .slow_ok(slow_ok),
        .main_en(MAIN_CLK_EN),
        .slow_en(SLOW_CLK_EN),
        .done(sw_done)
    );

    // In Save and Idle the oscillator may only stop when the slow clock does not need it; Halt always stops it
    wire osc_off_ok = fast_osc_disable_reg && lfo_src;
    assign FAST_OSC_EN = is_halt ? 1'b0 :
        (is_save || is_idle) ? !osc_off_ok : 1'b1;
    assign LOW_OSC_EN = 1'b1;
    // Internal slow clock stops in Halt; timer and this unit freeze
    assign TIMER_CLK_EN = slow_ok && !is_halt;
    assign PMU_CLK_EN = slow_ok && !is_halt;
    assign CPU_STALL = stall_reg;
    assign WAKE_PENDING = wake_pend;
    assign REG_RDATA = rdata_reg;
    assign MODE = state_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    sequence imm_save_req;
        REG_WR && is_active && wr_save && !wr_defer && slow_ok && !wake_evt;
    endsequence
    sequence enter_pending;
        is_enter && !power_save_request_reg;
    endsequence

    reset_active_a: assert property ($past(SYS_RST) |-> is_active)
        else $error("not in active mode after reset");
    halt_dark_a: assert property (is_halt |-> !FAST_OSC_EN && !TIMER_CLK_EN
        && !MAIN_CLK_EN && !SLOW_CLK_EN)
        else $error("clock or oscillator running in halt");
    lfo_on_a: assert property (LOW_OSC_EN)
        else $error("low-frequency oscillator disabled");
    osc_keep_a: assert property ((is_save || is_idle) && !lfo_src |-> FAST_OSC_EN)
        else $error("fast oscillator off while feeding slow clock");
    active_clk_a: assert property (is_active && sw_done |->
        MAIN_CLK_EN == fast_ok && !SLOW_CLK_EN && TIMER_CLK_EN == slow_ok)
        else $error("active mode clocking wrong");
    save_clk_a: assert property (is_save && sw_done |->
        SLOW_CLK_EN == slow_ok && !MAIN_CLK_EN)
        else $error("power save clocking wrong");
    idle_clk_a: assert property (is_idle |-> !MAIN_CLK_EN && !SLOW_CLK_EN
        && PMU_CLK_EN == slow_ok)
        else $error("idle mode clocking wrong");
    imm_save_a: assert property (imm_save_req |=> enter_pending)
        else $error("immediate save bit set early");
    defer_bit_a: assert property (REG_WR && is_active && wr_save && wr_defer
        && !wake_evt |=> power_save_request_reg && is_active)
        else $error("deferred save bit not set at once");
    wake_clear_a: assert property (wake_evt && asleep |=>
        is_leave && !fast_osc_disable_reg && !idle_reg && !halt_reg)
        else $error("wake-up did not clear mode bits");
    leave_gate_a: assert property (is_leave && !fast_ok |=> !is_active)
        else $error("active entered without stable fast clock");
    stall_hold_a: assert property (CPU_STALL && !INT_REQ && !(wake_pend && is_active)
        |=> CPU_STALL)
        else $error("core released without interrupt");
endmodule

// ---- rtl/pmu_wake_latch.sv ----
// Wake-up event latch, held until interrupt acknowledge
`timescale 1ns/1ps
module pmu_wake_latch (
    input wire logic clk,
    input wire logic rst,
    input wire logic wake_irq,
    input wire logic nmi,
    input wire logic int_ack,
    output logic pending,
    output logic wake_event
);
    logic pend_reg;
    logic pend_next;
    logic nmi_d_reg;
    assign wake_event = wake_irq || (nmi && !nmi_d_reg);
    // New event beats a same-cycle acknowledge
    assign pend_next = wake_event || (pend_reg && !int_ack);
    assign pending = pend_reg;
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pend_reg <= 1'b0;
            nmi_d_reg <= 1'b0;
        end
        else
        begin
            pend_reg <= pend_next;
            nmi_d_reg <= nmi;
        end
    end
    pend_hold_a: assert property (@(posedge clk) disable iff (rst)
        pend_reg && !int_ack |=> pend_reg)
        else $error("wake latch dropped without acknowledge");
    set_wins_a: assert property (@(posedge clk) disable iff (rst)
        wake_event |=> pend_reg)
        else $error("wake event lost");
endmodule

// ---- test/pmu_clk_model.sv ----
// Behavioural clock and reset unit feeding the power mode unit
`timescale 1ns/1ps
module pmu_clk_model #(
    parameter int FAST_LAG = 4,
    parameter int SLOW_LAG = 4
) (
    input wire logic clk,
    input wire logic fast_osc_en,
    input wire logic slow_run,
    output logic fast_ok,
    output logic slow_ok
);
    int fast_cnt = 0;
    int slow_cnt = 0;
    // Stable only after a start-up delay; drops at once when the source stops
    always @(posedge clk)
    begin
        if (fast_osc_en !== 1'b1)
            fast_cnt <= 0;
        else if (fast_cnt < FAST_LAG)
            fast_cnt <= fast_cnt + 1;
        if (slow_run !== 1'b1)
            slow_cnt <= 0;
        else if (slow_cnt < SLOW_LAG)
            slow_cnt <= slow_cnt + 1;
    end
    assign fast_ok = (fast_cnt >= FAST_LAG);
    assign slow_ok = (slow_cnt >= SLOW_LAG);
endmodule

// ---- test/pmu_top_tb_top.sv ----
// Self-checking bench for the power mode unit
`timescale 1ns/1ps
module pmu_top_tb_top;
    import pmu_pkg::*;
    logic mclk = 0, sys_rst = 1, slow_src_lfo = 0, reset_clk_slow = 1, slow_run = 0;
    logic wake_irq = 0, nmi = 0, reg_wr = 0, wait_exec = 0, int_req = 0, int_ack = 0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    pmu_state_t mode;
    logic fast_ok, slow_ok, fast_osc_en, low_osc_en, main_clk_en, slow_clk_en;
    logic timer_clk_en, pmu_clk_en, cpu_stall, wake_pending;
    logic [2:0] fok_h = 3'h0, sok_h = 3'h0;
    int err_total = 0;
    int cmp_count = 0;

    pmu_top pmu_top_inst (.MCLK(mclk), .SYS_RST(sys_rst), .FAST_CLOCK_STABLE(fast_ok),
        .SLOW_CLOCK_STABLE(slow_ok), .SLOW_SRC_LFO(slow_src_lfo),
        .RESET_CLK_SLOW(reset_clk_slow), .WAKE_IRQ(wake_irq), .NMI(nmi), .REG_WR(reg_wr),
        .REG_WDATA(reg_wdata), .WAIT_EXEC(wait_exec), .INT_REQ(int_req), .INT_ACK(int_ack),
        .REG_RDATA(reg_rdata), .MODE(mode), .FAST_OSC_EN(fast_osc_en),
        .LOW_OSC_EN(low_osc_en), .MAIN_CLK_EN(main_clk_en), .SLOW_CLK_EN(slow_clk_en),
        .TIMER_CLK_EN(timer_clk_en), .PMU_CLK_EN(pmu_clk_en), .CPU_STALL(cpu_stall),
        .WAKE_PENDING(wake_pending));
    pmu_clk_model pmu_clk_model_inst (.clk(mclk), .fast_osc_en(fast_osc_en),
        .slow_run(slow_run), .fast_ok(fast_ok), .slow_ok(slow_ok));

    initial
    begin
        forever #5 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task chk1(input string what, input logic exp, input logic got);
        chk(what, {7'h0, exp}, {7'h0, got});
    endtask
    task tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task wait_mode(input pmu_state_t m, input int lim);
        int i;
        for (i = 0; i < lim; i++)
        begin
            tick(1);
            if (mode === m)
                break;
        end
        chk("mode", {2'h0, m}, {2'h0, mode});
    endtask
    task wr(input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task wt();
        @(posedge mclk);
        wait_exec <= 1'b1;
        @(posedge mclk);
        wait_exec <= 1'b0;
    endtask
    // 0 maskable wake, 1 nmi, 2 interrupt request, 3 acknowledge
    task pulse(input int k);
        @(posedge mclk);
        case (k)
            0: wake_irq <= 1'b1;
            1: nmi <= 1'b1;
            2: int_req <= 1'b1;
            default: int_ack <= 1'b1;
        endcase
        @(posedge mclk);
        {wake_irq, nmi, int_req, int_ack} <= 4'h0;
    endtask
    task stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Sampled mid-cycle so the combinational gates have settled
    always @(negedge mclk)
    begin
        fok_h <= {fok_h[1:0], fast_ok};
        sok_h <= {sok_h[1:0], slow_ok};
        if (main_clk_en === 1'b1 && slow_clk_en === 1'b1)
            chk1("gate overlap", 1'b0, 1'b1);
        if (main_clk_en === 1'b1 && fok_h === 3'h0)
            chk1("main without stable", 1'b0, 1'b1);
        if (slow_clk_en === 1'b1 && sok_h === 3'h0)
            chk1("slow without stable", 1'b0, 1'b1);
        if (low_osc_en !== 1'b1)
            chk1("low osc", 1'b1, low_osc_en);
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset(input logic rsel, input logic srun);
        @(posedge mclk);
        sys_rst <= 1'b1;
        reset_clk_slow <= rsel;
        slow_run <= srun;
        tick(10);
        chk("mode", {2'h0, PMU_ST_ACTIVE}, {2'h0, mode});
        chk("status", 8'h00, reg_rdata);
        chk1("main in reset", ~rsel, main_clk_en);
        chk1("slow in reset", rsel & srun, slow_clk_en);
        chk1("fast osc", 1'b1, fast_osc_en);
        chk1("stall", 1'b0, cpu_stall);
        @(posedge mclk);
        sys_rst <= 1'b0;
        $display("test done: reset");
    endtask
    task t_refused();
        @(posedge mclk);
        slow_run <= 1'b0;
        tick(8);
        wr(8'h01);
        tick(4);
        chk("mode", {2'h0, PMU_ST_ACTIVE}, {2'h0, mode});
        chk1("save bit", 1'b0, reg_rdata[0]);
        chk1("slow status", 1'b0, reg_rdata[7]);
        @(posedge mclk);
        slow_run <= 1'b1;
        tick(10);
        chk1("slow status", 1'b1, reg_rdata[7]);
        chk1("timer gate", 1'b1, timer_clk_en);
        $display("test done: refused");
    endtask
    task t_save_imm();
        wr(8'h01);
        tick(1);
        chk("mode", {2'h0, PMU_ST_ENTER_SAVE}, {2'h0, mode});
        chk1("main gate", 1'b0, main_clk_en);
        wait_mode(PMU_ST_SAVE, 20);
        chk1("slow gate", 1'b1, slow_clk_en);
        chk1("timer gate", 1'b1, timer_clk_en);
        chk1("stall", 1'b0, cpu_stall);
        tick(1);
        chk1("save bit", 1'b1, reg_rdata[0]);
        wr(8'h00);
        wait_mode(PMU_ST_ACTIVE, 30);
        chk1("main gate", 1'b1, main_clk_en);
        tick(2);
        chk1("save bit", 1'b0, reg_rdata[0]);
        $display("test done: save_imm");
    endtask
    task t_wait_only();
        wt();
        tick(6);
        chk1("stall", 1'b1, cpu_stall);
        chk("mode", {2'h0, PMU_ST_ACTIVE}, {2'h0, mode});
        pulse(2);
        tick(2);
        chk1("stall", 1'b0, cpu_stall);
        $display("test done: wait_only");
    endtask
    task t_wake(input int k);
        pulse(k);
        tick(4);
        chk1("pending", 1'b1, wake_pending);
        wait_mode(PMU_ST_ACTIVE, 40);
        tick(2);
        chk("bits", 8'h00, {4'h0, reg_rdata[3:0]});
        chk1("fast osc", 1'b1, fast_osc_en);
        chk1("pending", 1'b1, wake_pending);
        chk1("stall", 1'b0, cpu_stall);
        pulse(3);
        tick(2);
        chk1("pending", 1'b0, wake_pending);
    endtask
    task t_deferred();
        wr(8'h21);
        tick(2);
        chk1("save bit", 1'b1, reg_rdata[0]);
        chk("mode", {2'h0, PMU_ST_ACTIVE}, {2'h0, mode});
        wt();
        wait_mode(PMU_ST_SAVE, 20);
        chk1("stall", 1'b1, cpu_stall);
        pulse(2);
        tick(2);
        chk1("stall", 1'b0, cpu_stall);
        t_wake(1);
        $display("test done: deferred");
    endtask
    task t_idle(input logic lfo);
        @(posedge mclk);
        slow_src_lfo <= lfo;
        tick(3);
        wr(8'h26);
        wt();
        wait_mode(PMU_ST_IDLE, 30);
        chk1("main gate", 1'b0, main_clk_en);
        chk1("slow gate", 1'b0, slow_clk_en);
        chk1("timer gate", 1'b1, timer_clk_en);
        chk1("unit gate", 1'b1, pmu_clk_en);
        chk1("fast osc", ~lfo, fast_osc_en);
        t_wake(lfo ? 1 : 0);
        $display("test done: idle");
    endtask
    task t_halt();
        wr(8'h28);
        wt();
        wait_mode(PMU_ST_HALT, 30);
        tick(20);
        chk("mode", {2'h0, PMU_ST_HALT}, {2'h0, mode});
        chk("gates", 4'h0, {main_clk_en, slow_clk_en, timer_clk_en, pmu_clk_en});
        chk1("fast osc", 1'b0, fast_osc_en);
        chk1("low osc", 1'b1, low_osc_en);
        t_wake(0);
        $display("test done: halt");
    endtask
    // Save, then Idle and Halt reached from the lower modes by WAIT
    task t_chain();
        wr(8'h01);
        wait_mode(PMU_ST_SAVE, 20);
        wr(8'h05);
        tick(2);
        chk("mode", {2'h0, PMU_ST_SAVE}, {2'h0, mode});
        wt();
        wait_mode(PMU_ST_IDLE, 4);
        chk("gates", 8'h03, {main_clk_en, slow_clk_en, timer_clk_en, pmu_clk_en});
        wr(8'h0D);
        wt();
        wait_mode(PMU_ST_HALT, 4);
        chk1("fast osc", 1'b0, fast_osc_en);
        t_wake(0);
        $display("test done: chain");
    endtask

    initial
    begin
        t_reset(1'b1, 1'b0);
        t_reset(1'b0, 1'b1);
        tick(16);
        t_refused();
        t_save_imm();
        t_wait_only();
        t_deferred();
        t_idle(1'b0);
        t_idle(1'b1);
        t_halt();
        t_chain();
        stop_test();
    end

    initial
    begin
        #200000;
        err_total++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
